// file: ptpgr_regs.sv
`timescale 1ns/10ps
// ptp global version/domain, unit index and trigger flag registers
// How it works
// - capture a received message only when its version equals setting
// - drop received timing packets with a mismatching version
// - with domain check on, capture only messages matching domain
// - with domain check off, the domain field is ignored
// - unit window accesses go to the selected timestamp/trigger unit
// - timestamp select bit picks unit 1 when set, resets to 0
// - trigger select codes 00,01,10 pick units 0..2; 11 reserved
// - late trigger with interrupt enable sets error flag, interrupts
// - error flag clears on trigger enable going low or write one
// - trigger done with interrupt enable sets done flag; w1c
// - config bit 4 enables domain check; mismatches are dropped
module ptpgr_regs
  import ptpgr_pkg::*;
(
  input  wire logic                      i_clk,            // system clock
  input  wire logic                      i_reset,          // sync reset
  input  wire logic [ptpgr_pkg::ADDR_W-1:0] i_address,     // byte address
  input  wire logic                      i_read,           // avalon read
  input  wire logic                      i_write,          // avalon write
  input  wire logic [3:0]                i_byteenable,     // byte lanes
  input  wire logic [31:0]               i_writedata,      // write data
  output logic [31:0]                    o_readdata,       // read data
  output logic                           o_waitrequest,    // stall
  output logic                           o_irq,            // interrupt
  input  wire logic                      i_msg_valid,      // rx msg strobe
  input  wire logic [3:0]                i_msg_version,    // rx version
  input  wire logic [7:0]                i_msg_domain,     // rx domain
  output logic                           o_msg_capture,    // take message
  output logic                           o_msg_drop,       // drop message
  input  wire logic [2:0]                i_trig_late,      // time < now
  input  wire logic [2:0]                i_trig_done,      // output made
  input  wire logic [2:0]                i_trig_int_en,    // notify enable
  input  wire logic [2:0]                i_trig_en,        // trigger enable
  output logic                           o_win_sel,        // window access
  output logic                           o_win_read,       // window read
  output logic                           o_win_write,      // window write
  output logic                           o_timestamp_unit_select, // ts unit
  output logic [2:0]                     o_trigger_unit_onehot,   // trig
  input  wire logic [31:0]               i_win_readdata,   // unit data
  output logic [3:0]                     o_version_setting, // version
  output logic [7:0]                     o_domain_match_value, // domain
  output logic                           o_domain_check_en // domain check
);
  import ptpgr_pkg::*;

  logic [3:0]  version_r;
  logic [7:0]  domain_match_value_r;
  logic        domain_check_r;
  logic        timestamp_unit_select_r;
  logic [1:0]  trigger_unit_select_r;
  logic [2:0]  trig_en_d_r;
  logic [2:0]  err_flag;
  logic [2:0]  done_flag;
  logic [2:0]  err_set;
  logic [2:0]  err_clr;
  logic [2:0]  done_clr;
  logic [5:0]  irq_status_r;
  logic [5:0]  irq_mask_r;
  logic [5:0]  irq_events;
  logic        ack_r;
  logic        req;
  logic        in_win;
  logic [31:0] rdata_nxt;
  logic [31:0] wmask;
  logic        wr_ver;
  logic        wr_cfg;
  logic        wr_idx;
  logic        wr_flags;
  logic        wr_mask;
  logic        rd_status;
  logic [31:0] flags_word;
  logic [31:0] ver_word;
  logic [31:0] cfg_word;
  logic [31:0] idx_word;
  logic [31:0] status_word;
  logic [31:0] mask_word;
  logic [2:0]  done_set;
  logic [2:0]  en_fall;
  logic        wr_err_lane;
  logic        wr_done_lane;
  logic [5:0]  status_seen;
  logic        rd_first;

  // one wait cycle per access, acked on the second
  assign req           = i_read | i_write;
  assign o_waitrequest = req & ~ack_r;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req & ~ack_r;
    end
  end

  assign wmask = {{8{i_byteenable[3]}}, {8{i_byteenable[2]}},
                  {8{i_byteenable[1]}}, {8{i_byteenable[0]}}};

  assign in_win = (i_address >= OFF_WIN_LO) && (i_address <= OFF_WIN_HI);

  wire   wr_go = i_write & ack_r;
  assign wr_ver    = wr_go && (i_address == OFF_VER_DOMAIN);
  assign wr_cfg    = wr_go && (i_address == OFF_MSG_CFG);
  assign wr_idx    = wr_go && (i_address == OFF_UNIT_INDEX);
  assign wr_flags  = wr_go && (i_address == OFF_TRIG_FLAGS);
  assign wr_mask   = wr_go && (i_address == OFF_IRQ_MASK);
  assign rd_status = i_read && ack_r && (i_address == OFF_IRQ_STATUS);

  // window strobes decode the address only; unit selection is left to the select outputs
  assign o_win_sel   = in_win & req;
  assign o_win_read  = in_win & i_read & ack_r;
  assign o_win_write = in_win & wr_go;
  assign o_timestamp_unit_select = timestamp_unit_select_r;

  always_comb begin
    o_trigger_unit_onehot = 3'b000;
    case (trigger_unit_select_r)
      2'h0: begin
        o_trigger_unit_onehot = 3'b001;
      end
      2'h1: begin
        o_trigger_unit_onehot = 3'b010;
      end
      2'h2: begin
        o_trigger_unit_onehot = 3'b100;
      end
      default: begin
        // reserved code reaches no trigger unit
        o_trigger_unit_onehot = 3'b000;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      version_r            <= VER_RST;
      domain_match_value_r <= DOM_RST;
    end else if (wr_ver) begin
      if (i_byteenable[1]) begin
        version_r <= i_writedata[VER_LSB +: VER_W];
      end
      if (i_byteenable[0]) begin
        domain_match_value_r <= i_writedata[DOM_LSB +: DOM_W];
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      domain_check_r <= 1'b0;
    end else if (wr_cfg && i_byteenable[0]) begin
      domain_check_r <= i_writedata[DOM_CHK_BIT];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      timestamp_unit_select_r <= 1'b0;
      trigger_unit_select_r   <= 2'h0;
    end else if (wr_idx) begin
      if (i_byteenable[1]) begin
        timestamp_unit_select_r <= i_writedata[TS_SEL_BIT];
      end
      if (i_byteenable[0]) begin
        trigger_unit_select_r <= i_writedata[TRIG_SEL_LSB +: 2];
      end
    end
  end

  assign o_version_setting    = version_r;
  assign o_domain_match_value = domain_match_value_r;
  assign o_domain_check_en    = domain_check_r;

  // message filter decision, registered
  wire ver_ok = (i_msg_version == version_r);
  wire dom_ok = ~domain_check_r |
                (i_msg_domain == domain_match_value_r);

  wire msg_pass = ver_ok & dom_ok;

  // capture pulse, one cycle after the message strobe
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_msg_capture <= 1'b0;
    end else begin
      o_msg_capture <= i_msg_valid & msg_pass;
    end
  end

  // drop pulse, never together with capture
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_msg_drop <= 1'b0;
    end else begin
      o_msg_drop <= i_msg_valid & ~msg_pass;
    end
  end

  // trigger enable falling edge clears the late flag
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      trig_en_d_r <= 3'b000;
    end else begin
      trig_en_d_r <= i_trig_en;
    end
  end

  // events only count with the unit's notify enable
  assign err_set  = i_trig_late & i_trig_int_en;
  assign done_set = i_trig_done & i_trig_int_en;

  // enable going low clears the late flag of that unit
  assign en_fall      = trig_en_d_r & ~i_trig_en;
  assign wr_err_lane  = wr_flags & i_byteenable[2];
  assign wr_done_lane = wr_flags & i_byteenable[0];

  // ones clear, zeros leave the flag alone
  assign err_clr  = en_fall |
                    ({3{wr_err_lane}} &
                     i_writedata[ERR_LSB +: N_TRIG]);
  assign done_clr = {3{wr_done_lane}} &
                    i_writedata[DONE_LSB +: N_TRIG];

  genvar g;
  generate
    // late error flags, bits 18..16
    for (g = 0; g < N_TRIG; g++) begin : g_err
      ptpgr_w1c_flag u_err (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .i_set   (err_set[g]),
        .i_clr   (err_clr[g]),
        .o_flag  (err_flag[g])
      );
    end
    // done flags, bits 2..0
    for (g = 0; g < N_TRIG; g++) begin : g_done
      ptpgr_w1c_flag u_done (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .i_set   (done_set[g]),
        .i_clr   (done_clr[g]),
        .o_flag  (done_flag[g])
      );
    end
  endgenerate

  // interrupt status: sticky, cleared by read, set wins
  assign irq_events = {err_set, done_set};

  // read data was loaded a cycle before the ack, so clear only
  // the bits actually returned; later events survive the read
  assign status_seen = o_readdata[5:0];

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      irq_status_r <= 6'h00;
    end else if (rd_status) begin
      irq_status_r <= (irq_status_r & ~status_seen) | irq_events;
    end else begin
      irq_status_r <= irq_status_r | irq_events;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      irq_mask_r <= 6'h00;
    end else if (wr_mask && i_byteenable[0]) begin
      irq_mask_r <= i_writedata[5:0] & wmask[5:0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(irq_status_r & irq_mask_r);
    end
  end

  // read-back words, reserved bits read as zero
  assign flags_word  = {13'h0000, err_flag, 13'h0000, done_flag};
  assign ver_word    = {20'h00000, version_r, domain_match_value_r};
  assign cfg_word    = {27'h0000000, domain_check_r, 4'h0};
  assign idx_word    = {23'h000000, timestamp_unit_select_r, 6'h00,
                        trigger_unit_select_r};
  assign status_word = {26'h0000000, irq_status_r};
  assign mask_word   = {26'h0000000, irq_mask_r};

  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (in_win) begin
      rdata_nxt = i_win_readdata;
    end else begin
      case (i_address)
        OFF_VER_DOMAIN: begin
          rdata_nxt = ver_word;
        end
        OFF_MSG_CFG: begin
          rdata_nxt = cfg_word;
        end
        OFF_UNIT_INDEX: begin
          rdata_nxt = idx_word;
        end
        OFF_TRIG_FLAGS: begin
          rdata_nxt = flags_word;
        end
        OFF_IRQ_STATUS: begin
          rdata_nxt = status_word;
        end
        OFF_IRQ_MASK: begin
          rdata_nxt = mask_word;
        end
        default: begin
          // unmapped addresses read zero
          rdata_nxt = 32'h0000_0000;
        end
      endcase
    end
  end

  // sampled in the wait cycle of a read
  assign rd_first = i_read & ~ack_r;

  // read data held in a flop, valid while waitrequest is low
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_readdata <= 32'h0000_0000;
    end else if (rd_first) begin
      o_readdata <= rdata_nxt;
    end
  end

endmodule // ptpgr_regs

// file: ptpgr_pkg.sv
// constants and register map for the ptp global index and status registers
package ptpgr_pkg;
  localparam int          ADDR_W          = 12;
  localparam logic [11:0] OFF_VER_DOMAIN  = 12'h518;
  localparam logic [11:0] OFF_MSG_CFG     = 12'h514;
  localparam logic [11:0] OFF_UNIT_INDEX  = 12'h520;
  localparam logic [11:0] OFF_TRIG_FLAGS  = 12'h524;
  localparam logic [11:0] OFF_IRQ_STATUS  = 12'h5c0;
  localparam logic [11:0] OFF_IRQ_MASK    = 12'h5c4;
  localparam logic [11:0] OFF_WIN_LO      = 12'h52c;
  localparam logic [11:0] OFF_WIN_HI      = 12'h5b3;
  localparam int          VER_LSB         = 8;
  localparam int          VER_W           = 4;
  localparam logic [3:0]  VER_RST         = 4'h2;
  localparam int          DOM_LSB         = 0;
  localparam int          DOM_W           = 8;
  localparam logic [7:0]  DOM_RST         = 8'h00;
  localparam int          DOM_CHK_BIT     = 4;
  localparam int          TS_SEL_BIT      = 8;
  localparam int          TRIG_SEL_LSB    = 0;
  localparam int          N_TRIG          = 3;
  localparam int          ERR_LSB         = 16;
  localparam int          DONE_LSB        = 0;
  localparam logic [1:0]  TRIG_SEL_RSVD   = 2'h3;
endpackage

// file: ptpgr_w1c_flag.sv
`timescale 1ns/10ps
// one sticky flag: hardware set beats software clear
module ptpgr_w1c_flag (
  input  wire logic i_clk,    // system clock
  input  wire logic i_reset,  // sync reset, active high
  input  wire logic i_set,    // hardware event
  input  wire logic i_clr,    // clearing request
  output logic      o_flag    // sticky flag
);
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_flag <= 1'b0;
    end else if (i_set) begin
      o_flag <= 1'b1;
    end else if (i_clr) begin
      o_flag <= 1'b0;
    end
  end
endmodule // ptpgr_w1c_flag

// file: ptpgr_regs_assertions.sv
// concurrent checks for the ptp global registers
`timescale 1ns/10ps
module ptpgr_regs_chk
  import ptpgr_pkg::*;
(
  input wire logic        i_clk,                   // clock
  input wire logic        i_reset,                 // reset
  input wire logic [11:0] i_address,               // address
  input wire logic        i_read,                  // read
  input wire logic        i_write,                 // write
  input wire logic [3:0]  i_byteenable,            // lanes
  input wire logic [31:0] i_writedata,             // wdata
  input wire logic [31:0] o_readdata,              // rdata
  input wire logic        o_waitrequest,           // stall
  input wire logic        i_msg_valid,             // msg strobe
  input wire logic [3:0]  i_msg_version,           // msg version
  input wire logic [7:0]  i_msg_domain,            // msg domain
  input wire logic        o_msg_capture,           // capture
  input wire logic        o_msg_drop,              // drop
  input wire logic [31:0] i_win_readdata,          // unit data
  input wire logic        o_timestamp_unit_select, // ts unit
  input wire logic [2:0]  o_trigger_unit_onehot,   // trig unit
  input wire logic [3:0]  o_version_setting,       // version
  input wire logic [7:0]  o_domain_match_value,    // domain
  input wire logic        o_domain_check_en        // domain check
);
  logic       acc_w, ver_ok, dom_ok, in_win, ts_bit;
  logic [2:0] trig_exp;
  logic [3:0] ver_wd;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  assign acc_w = i_write && !o_waitrequest;
  assign ver_ok = i_msg_version == o_version_setting;
  assign dom_ok = !o_domain_check_en || i_msg_domain == o_domain_match_value;
  assign in_win = i_address >= OFF_WIN_LO && i_address <= OFF_WIN_HI;
  assign ts_bit = i_writedata[TS_SEL_BIT];
  assign ver_wd = i_writedata[11:8];
  assign trig_exp = (i_writedata[1:0] == TRIG_SEL_RSVD) ? 3'h0
                  : 3'h1 << i_writedata[1:0];
  a_msg_taken: assert property (i_msg_valid && ver_ok && dom_ok
    |=> o_msg_capture && !o_msg_drop) else $error("message not taken");
  a_version_drop: assert property (i_msg_valid && !ver_ok
    |=> o_msg_drop && !o_msg_capture) else $error("bad version kept");
  a_domain_drop: assert property (i_msg_valid && !dom_ok
    |=> o_msg_drop && !o_msg_capture) else $error("bad domain kept");
  a_msg_quiet: assert property (!i_msg_valid
    |=> !o_msg_capture && !o_msg_drop) else $error("spurious verdict");
  a_win_data: assert property (i_read && o_waitrequest && in_win
    |=> !o_waitrequest && o_readdata == $past(i_win_readdata))
    else $error("window data wrong");
  a_ts_sel_wr: assert property (acc_w && i_address == OFF_UNIT_INDEX
    && i_byteenable[1] |=> o_timestamp_unit_select == $past(ts_bit))
    else $error("ts select wrong");
  a_trig_sel_wr: assert property (acc_w && i_address == OFF_UNIT_INDEX
    && i_byteenable[0] |=> o_trigger_unit_onehot == $past(trig_exp))
    else $error("trigger select wrong");
  a_version_wr: assert property (acc_w && i_address == OFF_VER_DOMAIN
    && i_byteenable[1] |=> o_version_setting == $past(ver_wd))
    else $error("version not stored");
  c_capture: cover property (o_msg_capture);
  c_drop: cover property (o_msg_drop);
  c_win: cover property (i_read && in_win && !o_waitrequest);
endmodule // ptpgr_regs_chk
bind ptpgr_regs ptpgr_regs_chk u_chk (.i_clk(i_clk), .i_reset(i_reset),
  .i_address(i_address), .i_read(i_read), .i_write(i_write),
  .i_byteenable(i_byteenable), .i_writedata(i_writedata),
  .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
  .i_msg_valid(i_msg_valid), .i_msg_version(i_msg_version),
  .i_msg_domain(i_msg_domain), .o_msg_capture(o_msg_capture),
  .o_msg_drop(o_msg_drop), .i_win_readdata(i_win_readdata),
  .o_timestamp_unit_select(o_timestamp_unit_select),
  .o_trigger_unit_onehot(o_trigger_unit_onehot),
  .o_version_setting(o_version_setting),
  .o_domain_match_value(o_domain_match_value),
  .o_domain_check_en(o_domain_check_en));

// file: tb_top.sv
// self-checking testbench for the ptp global registers
`timescale 1ns/10ps
module tb_top;
  import ptpgr_pkg::*;
  logic        i_clk, i_reset, i_read, i_write, i_msg_valid, o_irq;
  logic        o_waitrequest, o_msg_capture, o_msg_drop, o_domain_check_en;
  logic        o_timestamp_unit_select;
  logic [11:0] i_address;
  logic [3:0]  i_byteenable, i_msg_version, o_version_setting;
  logic [31:0] i_writedata, o_readdata, i_win_readdata, rd;
  logic [7:0]  i_msg_domain, o_domain_match_value;
  logic [2:0]  i_trig_late, i_trig_done, i_trig_int_en, i_trig_en;
  logic [2:0]  o_trigger_unit_onehot;
  int          n_mismatch, checks_done, cyc;
  ptpgr_regs u_dut (.i_clk(i_clk), .i_reset(i_reset), .i_address(i_address),
    .i_read(i_read), .i_write(i_write), .i_byteenable(i_byteenable),
    .i_writedata(i_writedata), .o_readdata(o_readdata),
    .o_waitrequest(o_waitrequest), .o_irq(o_irq), .i_msg_valid(i_msg_valid),
    .i_msg_version(i_msg_version), .i_msg_domain(i_msg_domain),
    .o_msg_capture(o_msg_capture), .o_msg_drop(o_msg_drop),
    .i_trig_late(i_trig_late), .i_trig_done(i_trig_done),
    .i_trig_int_en(i_trig_int_en), .i_trig_en(i_trig_en), .o_win_sel(),
    .o_win_read(), .o_win_write(),
    .o_timestamp_unit_select(o_timestamp_unit_select),
    .o_trigger_unit_onehot(o_trigger_unit_onehot),
    .i_win_readdata(i_win_readdata), .o_version_setting(o_version_setting),
    .o_domain_match_value(o_domain_match_value),
    .o_domain_check_en(o_domain_check_en));
  task automatic chk(input string nm, input logic [31:0] e, g);
    checks_done++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      n_mismatch++;
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // one avalon access; read data lands in rd
  task automatic bus(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    i_address <= a;
    i_writedata <= d;
    i_write <= wr;
    i_read <= !wr;
    do @(posedge i_clk); while (o_waitrequest !== 1'b0);
    rd = o_readdata;
    i_write <= 1'b0;
    i_read <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic msg(input logic [3:0] v, input logic [7:0] dm,
                     input logic cap);
    i_msg_valid <= 1'b1;
    i_msg_version <= v;
    i_msg_domain <= dm;
    @(posedge i_clk);
    i_msg_valid <= 1'b0;
    @(negedge i_clk);
    chk("capture", 32'(cap), 32'(o_msg_capture));
    chk("drop", 32'(!cap), 32'(o_msg_drop));
    @(posedge i_clk);
  endtask
  task automatic t_reset_values;
    bus(0, OFF_VER_DOMAIN, 0);
    chk("ver_domain", 32'h200, rd);
    bus(0, OFF_UNIT_INDEX, 0);
    chk("index", 32'h0, rd);
    chk("onehot", 32'h1, 32'(o_trigger_unit_onehot));
    bus(0, 12'h7f0, 0);
    chk("unmapped", 32'h0, rd);
  endtask
  task automatic t_messages;
    msg(4'h2, 8'h33, 1'b1);
    msg(4'h3, 8'h00, 1'b0);
    bus(1, OFF_VER_DOMAIN, 32'h35a);
    msg(4'h3, 8'h77, 1'b1);
    bus(1, OFF_MSG_CFG, 32'h10);
    msg(4'h3, 8'h5a, 1'b1);
    msg(4'h3, 8'h5b, 1'b0);
    msg(4'h2, 8'h5a, 1'b0);
    bus(1, OFF_MSG_CFG, 32'h0);
  endtask
  task automatic t_index;
    for (int i = 0; i < 4; i++) begin
      i_win_readdata <= 32'ha5a50000 + 32'(i);
      bus(1, OFF_UNIT_INDEX, 32'(i[0]) << 8 | 32'(i[1:0]));
      chk("ts_sel", 32'(i[0]), 32'(o_timestamp_unit_select));
      chk("onehot", i == 3 ? 0 : 1 << i, 32'(o_trigger_unit_onehot));
      bus(0, OFF_WIN_LO + 12'(4 * i), 0);
      chk("window", 32'ha5a50000 + 32'(i), rd);
    end
  endtask
  task automatic t_flags;
    bus(1, OFF_IRQ_MASK, 32'h3f);
    i_trig_late <= 3'b010;
    @(posedge i_clk);
    i_trig_late <= 3'b000;
    bus(0, OFF_TRIG_FLAGS, 0);
    chk("err_set", 32'h20000, rd);
    chk("irq", 32'h1, 32'(o_irq));
    bus(1, OFF_TRIG_FLAGS, 32'h0);
    bus(0, OFF_TRIG_FLAGS, 0);
    chk("zero_write", 32'h20000, rd);
    bus(1, OFF_TRIG_FLAGS, 32'h20000);
    bus(0, OFF_TRIG_FLAGS, 0);
    chk("w1c", 32'h0, rd);
    i_trig_late <= 3'b010;
    @(posedge i_clk);
    i_trig_late <= 3'b000;
    i_trig_en <= 3'b101;
    @(posedge i_clk);
    i_trig_en <= 3'b111;
    i_trig_int_en <= 3'b011;
    i_trig_done <= 3'b100;
    bus(0, OFF_TRIG_FLAGS, 0);
    chk("en_clear", 32'h0, rd);
    i_trig_int_en <= 3'b111;
    @(posedge i_clk);
    i_trig_done <= 3'b000;
    bus(0, OFF_TRIG_FLAGS, 0);
    chk("done_set", 32'h4, rd);
    bus(1, OFF_TRIG_FLAGS, 32'h4);
    bus(0, OFF_IRQ_STATUS, 0);
    chk("status", 32'h14, rd);
    bus(0, OFF_IRQ_STATUS, 0);
    chk("status_clr", 32'h0, rd);
    chk("irq_low", 32'h0, 32'(o_irq));
  endtask
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch++;
      final_report();
    end
  end
  initial begin
    {i_read, i_write, i_msg_valid, i_address, i_writedata} = '0;
    {i_msg_version, i_msg_domain, i_trig_late, i_trig_done} = '0;
    {i_win_readdata, n_mismatch, checks_done, cyc} = '0;
    i_byteenable = 4'hf;
    i_trig_int_en = 3'b111;
    i_trig_en = 3'b111;
    i_reset = 1'b1;
    repeat (5) @(posedge i_clk);
    i_reset <= 1'b0;
    t_reset_values();
    t_messages();
    t_index();
    t_flags();
    final_report();
  end
endmodule // tb_top
